// ==== via_arbiter.sv ====
// vectored interrupt arbiter: ranking, vector select, trap flag, port l edges
// assumes a cpu sequencer on the same clock and a classic wishbone master
// Notes on behaviour
// - fixed ranking, trap highest, default lowest
// - even low-byte code per winning source
// - no active source gives default E0
// - code replaces pc low byte only
// - sources sampled in first vis cycle
// - two-byte vector fetched, high byte first
// - table page follows the vis location
// - trap flag set by trap, reset clears
// - trap flag has no register address
// - clear-trap instruction clears the flag unless a trap occurs in the same cycle
// - zero opcode fetch raises trap immediately
// - unimplemented memory reads zero, decodes trap
// - stack overpop past limit raises trap
// - trap keeps enable, blocks maskable sources
// - only trap may interrupt trap handler
// - fetch trap pushes its own opcode address, overpop trap pushes nothing
// - eight port l edge lines, one vector
// - per-line enable and edge polarity
// - per-line pending latch, no summary flag
// - port l needs pending, enable, group, global
// - wake resumes after sleep unless enabled
// - acknowledge clears enable, pushes, jumps 00FF
// - return sets enable, pops counter
// - acknowledge only at instruction boundary
//
// The address map and the Wishbone register port were decided locally.
`include "via_params.svh"
`timescale 1ns/1ps
`default_nettype none
module via_arbiter (
  input  wire logic            core_clk_in,   // 250 MHz instruction clock
  input  wire logic            srst_in,       // synchronous reset, active high
  input  wire logic            clk_en_in,     // freezes all state while low
  input  wire via_pkg::via_seq_s seq_in,      // sequencer commands
  input  wire logic [9:0]      src_req_in,    // maskable source events, same clock
  input  wire logic [7:0]      portl_in,      // port l pins, asynchronous
  input  wire logic            mem_oob_in,    // fetch address beyond memory
  input  wire logic [7:0]      wb_adr_in,     // wishbone address
  input  wire logic [31:0]     wb_dat_in,     // wishbone write data
  input  wire logic [3:0]      wb_sel_in,     // wishbone byte selects
  input  wire logic            wb_we_in,      // wishbone write
  input  wire logic            wb_cyc_in,     // wishbone cycle
  input  wire logic            wb_stb_in,     // wishbone strobe
  output var  logic [31:0]     wb_dat_out,    // wishbone read data
  output var  logic            wb_ack_out,    // wishbone acknowledge
  output var  via_pkg::via_cpu_s cpu_out,     // answers to sequencer
  output var  logic            irq_req_out,   // acknowledge wanted at boundary
  output var  logic            wake_out,      // port l wake request
  output var  logic            wake_irq_out,  // wake will run a service routine
  output var  logic            trap_out       // trap pending, for sequencer only
);
  // ---------------------------------------------------------------
  // state declarations
  // ---------------------------------------------------------------
  logic [7:0]  ctrl;                 // global enable, group enable, ram size
  logic [9:0]  src_en;               // maskable source enables
  logic [9:0]  src_pnd;              // maskable source pending
  logic [7:0]  wake_line_enable_reg; // per-line port l enables
  logic [7:0]  wake_edge_select_reg; // 1 selects falling edge
  logic [7:0]  wake_line_pending_reg;// per-line port l pending
  logic        trap_pending_flag;    // not mapped on the bus
  logic [7:0]  pl_sync1;             // port l first sync stage
  logic [7:0]  pl_sync2;             // port l second sync stage
  logic [7:0]  pl_prev;              // port l previous level
  logic [7:0]  vec_code;             // code caught in first vis cycle
  logic [15:0] vec_base;             // page plus code
  logic [2:0]  ack_cnt;              // acknowledge cycle counter
  via_pkg::via_state_e state;        // acknowledge sequencer
  via_pkg::via_state_e next_state;   // next sequencer state
  // ---------------------------------------------------------------
  // combinational decode
  // ---------------------------------------------------------------
  wire        global_irq_enable        = ctrl[`VIA_CTRL_GIE];
  wire        portl_group_irq_enable       = ctrl[`VIA_CTRL_PORTL_GROUP_IRQ_ENABLE];
  wire [7:0]  stk_limit  = ctrl[`VIA_CTRL_BIGRAM] ? `VIA_STK_LIM_LARGE
                                                  : `VIA_STK_LIM_SMALL;
  // zero opcode or out-of-range read is a trap
  wire        trap_fetch = seq_in.fetch &&
                           (mem_oob_in || seq_in.opcode == `VIA_TRAP_OPCODE);
  wire        overpop    = seq_in.stk_pop && (seq_in.sp > stk_limit);
  wire        trap_event = trap_fetch || overpop;
  // each maskable source active only with enable and pending
  wire [9:0]  src_act    = src_en & src_pnd;
  wire        pl_act     = |(wake_line_pending_reg & wake_line_enable_reg) && portl_group_irq_enable;
  // maskable sources blocked by trap pending or disabled global enable
  wire        mask_ok    = global_irq_enable && !trap_pending_flag;
  wire        any_mask   = (|src_act || pl_act) && mask_ok;
  wire [7:0]  pl_rise    = pl_sync2 & ~pl_prev;
  wire [7:0]  pl_fall    = ~pl_sync2 & pl_prev;
  wire [7:0]  pl_trig    = (wake_edge_select_reg & pl_fall) |
                           (~wake_edge_select_reg & pl_rise);
  wire        bus_req    = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire        bus_wr     = bus_req && wb_we_in && wb_sel_in[0];
  wire        wr_ctrl    = bus_wr && wb_adr_in == `VIA_OFS_CTRL;
  wire        wr_en      = bus_wr && wb_adr_in == `VIA_OFS_SRC_EN;
  wire        wr_pnd     = bus_wr && wb_adr_in == `VIA_OFS_SRC_PND;
  wire        wr_wake_line_enable_reg    = bus_wr && wb_adr_in == `VIA_OFS_WK_EN;
  wire        wr_wake_edge_select_reg   = bus_wr && wb_adr_in == `VIA_OFS_WK_EDG;
  wire        wr_wake_line_pending_reg   = bus_wr && wb_adr_in == `VIA_OFS_WK_PND;
  // fixed ranking: trap, ext, idle, t1a, t1b, serial, t2a, t2b, t3a, t3b, port l
  wire [7:0]  rank_code  =
      trap_pending_flag       ? `VIA_VEC_TRAP :
      !global_irq_enable                    ? `VIA_VEC_DEFAULT :
      src_act[0]              ? `VIA_VEC_EXT :
      src_act[1]              ? `VIA_VEC_IDLE :
      src_act[2]              ? `VIA_VEC_T1A :
      src_act[3]              ? `VIA_VEC_T1B :
      src_act[4]              ? `VIA_VEC_SER :
      src_act[5]              ? `VIA_VEC_T2A :
      src_act[6]              ? `VIA_VEC_T2B :
      src_act[7]              ? `VIA_VEC_T3A :
      src_act[8]              ? `VIA_VEC_T3B :
      pl_act                  ? `VIA_VEC_PORTL :
                                `VIA_VEC_DEFAULT;
  // page from the counter after the vis opcode fetch
  wire [15:0] pc_inc     = seq_in.fetch_pc + 16'h0001;
  wire        vis_go     = seq_in.vis_first && state == via_pkg::VIA_IDLE;
  wire        ack_go     = seq_in.boundary && state == via_pkg::VIA_IDLE &&
                           any_mask && !trap_event;
  // ---------------------------------------------------------------
  // next state of the acknowledge sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      via_pkg::VIA_IDLE: begin
        if (vis_go) begin
          next_state = via_pkg::VIA_VHI;
        end else if (ack_go) begin
          next_state = via_pkg::VIA_ACK;
        end
      end
      via_pkg::VIA_ACK: begin
        if (ack_cnt == `VIA_ACK_CYCLES - 3'h1) begin
          next_state = via_pkg::VIA_IDLE;
        end
      end
      via_pkg::VIA_VHI: next_state = via_pkg::VIA_VLO;
      via_pkg::VIA_VLO: next_state = via_pkg::VIA_IDLE;
      default:          next_state = via_pkg::VIA_IDLE;
    endcase
  end
  // ---------------------------------------------------------------
  // acknowledge and vector sequencing
  // ---------------------------------------------------------------
  // sequencer and cpu answers
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state    <= via_pkg::VIA_IDLE;
      ack_cnt  <= 3'h0;
      vec_code <= `VIA_VEC_DEFAULT;
      vec_base <= 16'h0000;
      cpu_out  <= '0;
    end else if (clk_en_in) begin
      state   <= next_state;
      cpu_out <= '0;
      if (trap_fetch) begin
        // trap pushes its own opcode address and enters at once
        cpu_out.push      <= 1'b1;
        cpu_out.push_addr <= seq_in.fetch_pc;
        cpu_out.pc_load   <= 1'b1;
        cpu_out.pc_val    <= `VIA_ISR_ENTRY;
      end
      if (vis_go) begin
        // code caught once; later source changes ignored
        vec_code <= rank_code;
        vec_base <= {pc_inc[15:8], rank_code};
      end
      if (state == via_pkg::VIA_ACK) begin
        ack_cnt          <= ack_cnt + 3'h1;
        cpu_out.ack_busy <= 1'b1;
        if (ack_cnt == 3'h0) begin
          cpu_out.push      <= 1'b1;
          cpu_out.push_addr <= seq_in.fetch_pc;
        end
        if (ack_cnt == `VIA_ACK_CYCLES - 3'h1) begin
          cpu_out.pc_load <= 1'b1;
          cpu_out.pc_val  <= `VIA_ISR_ENTRY;
        end
      end else begin
        ack_cnt <= 3'h0;
      end
      if (state == via_pkg::VIA_VHI) begin
        // high byte at the even address, then low byte
        cpu_out.vec_fetch <= 1'b1;
        cpu_out.pc_val    <= vec_base;
      end
      if (state == via_pkg::VIA_VLO) begin
        cpu_out.vec_fetch <= 1'b1;
        cpu_out.pc_val    <= vec_base + 16'h0001;
      end
    end
  end
  // ---------------------------------------------------------------
  // trap pending flag, set wins over clear
  // ---------------------------------------------------------------
  // flag lives outside the bus map
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      trap_pending_flag <= 1'b0;
    end else if (clk_en_in) begin
      if (trap_event) begin
        trap_pending_flag <= 1'b1;
      end else if (seq_in.clr_trap) begin
        trap_pending_flag <= 1'b0;
      end
    end
  end
  // ---------------------------------------------------------------
  // control and global enable
  // ---------------------------------------------------------------
  // acknowledge clears enable, return sets it, trap leaves it
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ctrl <= `VIA_RST_CTRL;
    end else if (clk_en_in) begin
      if (ack_go) begin
        ctrl[`VIA_CTRL_GIE] <= 1'b0;
      end else if (seq_in.return_from_irq_instr) begin
        ctrl[`VIA_CTRL_GIE] <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl <= wb_dat_in[7:0];
      end
    end
  end
  // ---------------------------------------------------------------
  // maskable sources and port l registers
  // ---------------------------------------------------------------
  // source pending: hardware set beats software clear
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      src_en                <= 10'h000;
      src_pnd               <= 10'h000;
      wake_line_enable_reg  <= 8'h00;
      wake_edge_select_reg  <= 8'h00;
      wake_line_pending_reg <= 8'h00;
    end else if (clk_en_in) begin
      if (wr_en) begin
        src_en <= wb_dat_in[9:0];
      end
      if (wr_wake_line_enable_reg) begin
        wake_line_enable_reg <= wb_dat_in[7:0];
      end
      if (wr_wake_edge_select_reg) begin
        wake_edge_select_reg <= wb_dat_in[7:0];
      end
      src_pnd <= (wr_pnd ? wb_dat_in[9:0] : src_pnd) | src_req_in;
      // each detected edge latched per line
      wake_line_pending_reg <= (wr_wake_line_pending_reg ? wb_dat_in[7:0] : wake_line_pending_reg)
                               | pl_trig;
    end
  end
  // ---------------------------------------------------------------
  // port l synchroniser and wake
  // ---------------------------------------------------------------
  // two flops before edge detection
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pl_sync1     <= 8'h00;
      pl_sync2     <= 8'h00;
      pl_prev      <= 8'h00;
      wake_out     <= 1'b0;
      wake_irq_out <= 1'b0;
      irq_req_out  <= 1'b0;
      trap_out     <= 1'b0;
    end else if (clk_en_in) begin
      pl_sync1 <= portl_in;
      pl_sync2 <= pl_sync1;
      pl_prev  <= pl_sync2;
      wake_out <= |(wake_line_pending_reg & wake_line_enable_reg);
      // service routine first only when interrupt enabled
      wake_irq_out <= pl_act && mask_ok;
      irq_req_out  <= any_mask;
      trap_out     <= trap_pending_flag;
    end
  end
  // ---------------------------------------------------------------
  // wishbone slave, one registered ack per request
  // ---------------------------------------------------------------
  wire [31:0] rd_mux =
      wb_adr_in == `VIA_OFS_CTRL    ? {24'h000000, ctrl} :
      wb_adr_in == `VIA_OFS_SRC_EN  ? {22'h000000 & 22'h3FFFFF, src_en} :
      wb_adr_in == `VIA_OFS_SRC_PND ? {22'h000000 & 22'h3FFFFF, src_pnd} :
      wb_adr_in == `VIA_OFS_WK_EN   ? {24'h000000, wake_line_enable_reg} :
      wb_adr_in == `VIA_OFS_WK_EDG  ? {24'h000000, wake_edge_select_reg} :
      wb_adr_in == `VIA_OFS_WK_PND  ? {24'h000000, wake_line_pending_reg} :
      wb_adr_in == `VIA_OFS_STATUS  ? {20'h00000, state, vec_code} :
      wb_adr_in == `VIA_OFS_STK_LIM ? {24'h000000, stk_limit} :
                                      32'h00000000;
  // ack one cycle after request, drop next cycle
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else if (clk_en_in) begin
      wb_ack_out <= bus_req;
      wb_dat_out <= bus_req ? rd_mux : 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// ==== via_params.svh ====
// constants for the vectored interrupt arbiter: register offsets, reset values, codes
// assumes inclusion by bare name from the arbiter package and module
`ifndef VIA_PARAMS_SVH
`define VIA_PARAMS_SVH
// register byte offsets on the wishbone slave
`define VIA_OFS_CTRL      8'h00
`define VIA_OFS_SRC_EN    8'h04
`define VIA_OFS_SRC_PND   8'h08
`define VIA_OFS_WK_EN     8'h0C
`define VIA_OFS_WK_EDG    8'h10
`define VIA_OFS_WK_PND    8'h14
`define VIA_OFS_STATUS    8'h18
`define VIA_OFS_STK_LIM   8'h1C
// control register bit positions
`define VIA_CTRL_GIE      0
`define VIA_CTRL_PORTL_GROUP_IRQ_ENABLE     1
`define VIA_CTRL_BIGRAM   2
// stack limits per ram size
`define VIA_STK_LIM_SMALL 8'h2F
`define VIA_STK_LIM_LARGE 8'h6F
// low-byte vector codes
`define VIA_VEC_TRAP      8'hFE
`define VIA_VEC_EXT       8'hFA
`define VIA_VEC_IDLE      8'hF8
`define VIA_VEC_T1A       8'hF6
`define VIA_VEC_T1B       8'hF4
`define VIA_VEC_SER       8'hF2
`define VIA_VEC_T2A       8'hEA
`define VIA_VEC_T2B       8'hE8
`define VIA_VEC_T3A       8'hE6
`define VIA_VEC_T3B       8'hE4
`define VIA_VEC_PORTL     8'hE2
`define VIA_VEC_DEFAULT   8'hE0
// opcode and acknowledge constants
`define VIA_TRAP_OPCODE   8'h00
`define VIA_ISR_ENTRY     16'h00FF
`define VIA_ACK_CYCLES    3'h7
`define VIA_RST_CTRL      8'h00
`endif

// ==== via_pkg.sv ====
// types shared by the vectored interrupt arbiter
// assumes via_params.svh sits in the same folder
`include "via_params.svh"
package via_pkg;
  // sequencer commands into the arbiter
  typedef struct packed {
    logic        fetch;      // opcode latched into instruction register
    logic [7:0]  opcode;     // opcode value fetched
    logic [15:0] fetch_pc;   // address of the fetched opcode
    logic        boundary;   // instruction boundary, skips done
    logic        vis_first;  // first cycle of vector-select instruction
    logic        clr_trap;   // clear-trap-pending instruction
    logic        return_from_irq_instr;       // return-from-interrupt instruction
    logic        stk_pop;    // stack pop this cycle
    logic [7:0]  sp;         // stack pointer after the pop
  } via_seq_s;
  // sequencer-facing answers
  typedef struct packed {
    logic        ack_busy;   // interrupt acknowledge sequence running
    logic        push;       // push strobe
    logic [15:0] push_addr;  // address to push
    logic        pc_load;    // program counter load strobe
    logic [15:0] pc_val;     // value to load
    logic        vec_fetch;  // fetch vector bytes at pc_val
  } via_cpu_s;
  // acknowledge state machine, one-hot
  typedef enum logic [3:0] {
    VIA_IDLE = 4'h1,
    VIA_ACK  = 4'h2,
    VIA_VHI  = 4'h4,
    VIA_VLO  = 4'h8
  } via_state_e;
endpackage

// ==== via_arbiter_monitor.sv ====
// concurrent checks on the vectored interrupt arbiter ports
// assumes clk_en_in stays high while the bench runs
`timescale 1ns/1ps
`default_nettype none
module via_arbiter_monitor (
  input wire logic              core_clk_in,  // instruction clock
  input wire logic              srst_in,      // synchronous reset
  input wire via_pkg::via_seq_s seq_in,       // sequencer commands
  input wire logic              mem_oob_in,   // fetch beyond memory
  input wire logic              wb_cyc_in,    // bus cycle
  input wire logic              wb_stb_in,    // bus strobe
  input wire logic              wb_ack_out,   // bus answer
  input wire via_pkg::via_cpu_s cpu_out,      // sequencer answers
  input wire logic              irq_req_out,  // acknowledge wanted
  input wire logic              wake_out,     // wake request
  input wire logic              wake_irq_out, // wake with service
  input wire logic              trap_out      // trap pending copy
);
  // ---------------------------------------------
  // helpers and clocking
  // ---------------------------------------------
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  logic trap_ev; // trap cause at a fetch
  assign trap_ev = seq_in.fetch && (seq_in.opcode == 8'h00 || mem_oob_in);
  chk_wb_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("bus answer missing");
  chk_wb_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("bus answer too long");
  chk_trap_push: assert property (trap_ev |=> cpu_out.push
    && cpu_out.push_addr == $past(seq_in.fetch_pc))
    else $error("trap pushed wrong address");
  chk_trap_jump: assert property (trap_ev |=> cpu_out.pc_load
    && cpu_out.pc_val == 16'h00FF)
    else $error("trap did not jump");
  chk_trap_flag: assert property (trap_ev |-> ##2 trap_out)
    else $error("trap flag not set");
  chk_overpop_trap: assert property (seq_in.stk_pop && seq_in.sp > 8'h6F |-> ##2 trap_out)
    else $error("overpop without trap");
  chk_trap_blocks: assert property ($rose(trap_out) |-> !irq_req_out)
    else $error("maskable request during trap");
  chk_ack_jump: assert property (seq_in.boundary && irq_req_out && !trap_ev
    |-> ##[1:9] (cpu_out.pc_load && cpu_out.pc_val == 16'h00FF))
    else $error("acknowledge did not jump");
  chk_ack_gie: assert property (seq_in.boundary && irq_req_out && !trap_ev
    |-> ##[1:2] !irq_req_out)
    else $error("enable kept after acknowledge");
  chk_vis_page: assert property (seq_in.vis_first |-> ##2 cpu_out.vec_fetch
    && cpu_out.pc_val[15:8] == 8'(($past(seq_in.fetch_pc, 2) + 16'h0001) >> 8)
    ##1 cpu_out.vec_fetch && cpu_out.pc_val[0])
    else $error("vector fetch page wrong");
  chk_vis_even: assert property (seq_in.vis_first |-> ##2 cpu_out.pc_val[7:5] == 3'h7
    && !cpu_out.pc_val[0] && !(cpu_out.pc_val[7:0] inside {8'hFC, 8'hF0, 8'hEE, 8'hEC}))
    else $error("vector code out of table");
  chk_wake_irq: assert property (wake_irq_out |-> wake_out)
    else $error("service wake without wake");
endmodule
bind via_arbiter via_arbiter_monitor u_mon (.core_clk_in, .srst_in, .seq_in, .mem_oob_in,
  .wb_cyc_in, .wb_stb_in, .wb_ack_out, .cpu_out, .irq_req_out, .wake_out, .wake_irq_out,
  .trap_out);
`default_nettype wire

// ==== via_seq_model.sv ====
// behavioural sequencer and pin source facing the arbiter
// assumes the bench calls its tasks from one process
`timescale 1ns/1ps
`default_nettype none
module via_seq_model (
  input  wire logic              core_clk_in, // instruction clock
  input  wire via_pkg::via_cpu_s cpu_in,      // arbiter answers
  output var  via_pkg::via_seq_s seq_out,     // commands
  output var  logic [9:0]        src_out,     // source event pulses
  output var  logic [7:0]        portl_out,   // port l pins
  output var  logic              oob_out      // fetch beyond memory
);
  logic [15:0] push_seen; // last pushed address
  logic [15:0] load_seen; // last counter load
  initial begin
    seq_out = '0;
    src_out = 10'h000;
    portl_out = 8'h00;
    oob_out = 1'b0;
    push_seen = 16'h0000;
    load_seen = 16'h0000;
  end
  // record stack pushes and counter loads
  always @(posedge core_clk_in) begin
    if (cpu_in.push) push_seen <= cpu_in.push_addr;
    if (cpu_in.pc_load) load_seen <= cpu_in.pc_val;
  end
  // one-cycle command; k = fetch,boundary,vis,clr,return_from_irq_instr,pop; address and sp stay put
  task automatic cmd(input logic [5:0] k, input logic [7:0] op, input logic [15:0] pc,
                     input logic [7:0] sp, input logic oob);
    via_pkg::via_seq_s s;
    s = '{k[5], op, pc, k[4], k[3], k[2], k[1], k[0], sp};
    @(posedge core_clk_in);
    seq_out <= s;
    oob_out <= oob;
    s = '{1'b0, op, pc, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, sp};
    @(posedge core_clk_in);
    seq_out <= s;
    oob_out <= 1'b0;
  endtask
  // fetch a vector-select opcode at pc, run it, return the first vector address
  task automatic vector_select_instr(input logic [15:0] pc, output logic [15:0] v);
    int n;
    cmd(6'h20, 8'hB4, pc, 8'h00, 1'b0);
    cmd(6'h08, 8'hB4, pc, 8'h00, 1'b0);
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (!cpu_in.vec_fetch && n < 8);
    v = cpu_in.vec_fetch ? cpu_in.pc_val : 16'h0000;
  endtask
  // source event pulse
  task automatic src(input logic [9:0] m);
    @(posedge core_clk_in);
    src_out <= m;
    @(posedge core_clk_in);
    src_out <= 10'h000;
  endtask
  // new pin levels
  task automatic pins(input logic [7:0] v);
    @(posedge core_clk_in);
    portl_out <= v;
  endtask
endmodule
`default_nettype wire

// ==== via_arbiter_test.sv ====
// self-checking bench for the vectored interrupt arbiter
// assumes the sequencer model and the port checker in the same folder
`timescale 1ns/1ps
`default_nettype none
module via_arbiter_test;
  logic clk, srst, wb_we, wb_cyc, wb_stb, ack, oob, irq, wake, wake_irq, trap;
  logic [7:0]  wb_adr;   // bus address
  logic [31:0] wb_dat;   // bus write data
  logic [31:0] rdat;     // bus read data
  logic [9:0]  srcv;     // source events
  logic [7:0]  portl;    // port l pins
  logic [15:0] v;        // vector address seen
  via_pkg::via_seq_s seq;
  via_pkg::via_cpu_s cpu;
  int n_errors = 0;
  int tests_run = 0;
  logic [7:0] codes [9] = '{8'hFA, 8'hF8, 8'hF6, 8'hF4, 8'hF2, 8'hEA, 8'hE8, 8'hE6, 8'hE4};
  via_arbiter uut (.core_clk_in(clk), .srst_in(srst), .clk_en_in(1'b1), .seq_in(seq),
    .src_req_in(srcv), .portl_in(portl), .mem_oob_in(oob), .wb_adr_in(wb_adr),
    .wb_dat_in(wb_dat), .wb_sel_in(4'hF), .wb_we_in(wb_we), .wb_cyc_in(wb_cyc),
    .wb_stb_in(wb_stb), .wb_dat_out(rdat), .wb_ack_out(ack), .cpu_out(cpu),
    .irq_req_out(irq), .wake_out(wake), .wake_irq_out(wake_irq), .trap_out(trap));
  via_seq_model seqm (.core_clk_in(clk), .cpu_in(cpu), .seq_out(seq), .src_out(srcv),
    .portl_out(portl), .oob_out(oob));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ---------------------------------------------
  // compare, bus and closing tasks
  // ---------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic single bus cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t bus answer timed out", $time);
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    wb(1'b0, a, 32'h0);
    check(rdat[15:0], exp);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test;
  end
  // ---------------------------------------------
  // test sequence
  // ---------------------------------------------
  initial begin
    {srst, wb_we, wb_cyc, wb_stb, wb_adr, wb_dat} = {1'b1, 43'h0};
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rd(8'h00, 16'h0000);
    rd(8'h1C, 16'h002F);
    wb(1'b1, 8'h1C, 32'h55);
    rd(8'h1C, 16'h002F);
    rd(8'h20, 16'h0000);
    wb(1'b1, 8'h00, 32'h4);
    rd(8'h1C, 16'h006F);
    $display("registers done");
    wb(1'b1, 8'h00, 32'h3);
    wb(1'b1, 8'h04, 32'h3FF);
    for (int i = 0; i < 9; i++) begin
      wb(1'b1, 8'h08, 32'h1FF & (32'h1FF << i));
      seqm.vector_select_instr(16'h01FF, v);
      check(v, {8'h02, codes[i]});
    end
    wb(1'b1, 8'h04, 32'h3FE);
    wb(1'b1, 8'h08, 32'h1);
    seqm.vector_select_instr(16'h00FF, v);
    check(v, 16'h01E0);
    wb(1'b1, 8'h08, 32'h0);
    seqm.src(10'h001);
    rd(8'h08, 16'h0001);
    wb(1'b1, 8'h08, 32'h0);
    $display("ranking done");
    wb(1'b1, 8'h0C, 32'h81);
    wb(1'b1, 8'h10, 32'h80);
    seqm.pins(8'h80);
    rd(8'h14, 16'h0000);
    seqm.pins(8'h01);
    repeat (5) @(posedge clk);
    rd(8'h14, 16'h0081);
    check({15'h0, wake}, 16'h0001);
    check({15'h0, wake_irq}, 16'h0001);
    seqm.vector_select_instr(16'h0150, v);
    check(v, 16'h01E2);
    wb(1'b1, 8'h00, 32'h1);
    seqm.vector_select_instr(16'h0150, v);
    check(v, 16'h01E0);
    check({15'h0, wake_irq}, 16'h0000);
    wb(1'b1, 8'h0C, 32'h0);
    $display("port l done");
    wb(1'b1, 8'h00, 32'h3);
    wb(1'b1, 8'h04, 32'h3FF);
    wb(1'b1, 8'h08, 32'h1FF);
    seqm.cmd(6'h20, 8'h00, 16'h0123, 8'h00, 1'b0);
    repeat (2) @(posedge clk);
    check(seqm.push_seen, 16'h0123);
    check(seqm.load_seen, 16'h00FF);
    check({15'h0, trap}, 16'h0001);
    check({15'h0, irq}, 16'h0000);
    seqm.vector_select_instr(16'h01FF, v);
    check(v, 16'h02FE);
    rd(8'h00, 16'h0003);
    seqm.cmd(6'h10, 8'hB4, 16'h0200, 8'h00, 1'b0);
    repeat (3) @(posedge clk);
    check({15'h0, cpu.ack_busy}, 16'h0000);
    seqm.cmd(6'h04, 8'hB4, 16'h0200, 8'h00, 1'b0);
    seqm.cmd(6'h04, 8'hB4, 16'h0200, 8'h00, 1'b0);
    repeat (3) @(posedge clk);
    check({15'h0, trap}, 16'h0000);
    check({15'h0, irq}, 16'h0001);
    check({15'h0, cpu.ack_busy}, 16'h0000);
    $display("trap done");
    seqm.cmd(6'h10, 8'hB4, 16'h0345, 8'h00, 1'b0);
    repeat (12) @(posedge clk);
    check(seqm.push_seen, 16'h0345);
    rd(8'h00, 16'h0002);
    seqm.cmd(6'h02, 8'hB4, 16'h0345, 8'h00, 1'b0);
    rd(8'h00, 16'h0003);
    wb(1'b1, 8'h00, 32'h0);
    $display("acknowledge done");
    seqm.cmd(6'h01, 8'hB4, 16'h0345, 8'h2F, 1'b0);
    repeat (3) @(posedge clk);
    check({15'h0, trap}, 16'h0000);
    seqm.cmd(6'h01, 8'hB4, 16'h0345, 8'h30, 1'b0);
    repeat (3) @(posedge clk);
    check({15'h0, trap}, 16'h0001);
    seqm.cmd(6'h04, 8'hB4, 16'h0345, 8'h00, 1'b0);
    seqm.cmd(6'h20, 8'hB4, 16'h7000, 8'h00, 1'b1);
    repeat (3) @(posedge clk);
    check({15'h0, trap}, 16'h0001);
    check(seqm.push_seen, 16'h7000);
    seqm.cmd(6'h04, 8'hB4, 16'h7000, 8'h00, 1'b0);
    wb(1'b1, 8'h00, 32'h4);
    seqm.cmd(6'h01, 8'hB4, 16'h7000, 8'h6F, 1'b0);
    repeat (3) @(posedge clk);
    check({15'h0, trap}, 16'h0000);
    seqm.cmd(6'h01, 8'hB4, 16'h7000, 8'h70, 1'b0);
    repeat (3) @(posedge clk);
    check({15'h0, trap}, 16'h0001);
    $display("trap causes done");
    finish_test;
  end
endmodule
`default_nettype wire
